/* File: duc_pkg.sv */
package duc_pkg;
  // ----------------------------------------
  // data widths and codes
  // ----------------------------------------
  localparam int NUM_CH = 8;
  localparam int CODE_W = 14;
  typedef logic [CODE_W-1:0] duc_code_t;
  typedef logic [NUM_CH-1:0][CODE_W-1:0] duc_bank_t;
  localparam duc_code_t CODE_ZERO = 14'h0000;
  localparam duc_code_t CODE_MID = 14'h2000;
  localparam duc_code_t OFFSET_SB = 14'h2666;
  localparam duc_code_t OFFSET_TC = 14'h0666;
  localparam duc_code_t GAIN_DEFAULT = 14'h0000;
  localparam duc_code_t ZERO_DEFAULT = 14'h0000;
  // ----------------------------------------
  // configuration frame bits
  // ----------------------------------------
  localparam int CFG_LOAD_BIT = 0;
  localparam int CFG_CORR_BIT = 1;
  // ----------------------------------------
  // device pin sampling
  // ----------------------------------------
  localparam int PIN_CLR = 0;
  localparam int PIN_LOAD = 1;
  localparam int PIN_RST = 2;
  localparam int PIN_CS = 3;
  localparam int PIN_RSEL = 4;
  localparam int PIN_FMT = 5;
  localparam int PIN_SGL = 6;
  localparam int NUM_PINS = 7;
  localparam logic [NUM_PINS-1:0] PIN_RESET = 7'h0f;
  localparam logic [2:0] POR_SETTLE = 3'h6;
  localparam logic [3:0] CORR_CYCLES = 4'h4;
  // ----------------------------------------
  // host timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int T9_NS = 50;
  localparam int T9_CYCLES = (T9_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] GAP_CYCLES = 8'(T9_CYCLES);
  localparam logic [7:0] FRAME_LOW_CYCLES = 8'h04;
  localparam logic [7:0] LOAD_LOW_CYCLES = 8'h04;
  // ----------------------------------------
  // host register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam int CTRL_CLR = 0;
  localparam int CTRL_LOAD = 1;
  localparam int CTRL_RST = 2;
  localparam int CTRL_RSEL = 3;
  localparam int CTRL_FMT = 4;
  localparam int CTRL_SGL = 5;
  localparam int CTRL_PULSE = 8;
  localparam logic [5:0] CTRL_RESET = 6'h07;
  localparam int CMD_CHAN_LSB = 16;
  localparam int CMD_CFG = 20;
  localparam int ST_BUSY = 0;
  localparam int ST_PULSE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_SDO = 3;
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,
    H_FRAME = 4'h2,
    H_GAP = 4'h4,
    H_PULSE = 4'h8
  } duc_host_state_t;
endpackage

/* File: duc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface duc_if;
  logic cs_n;
  logic [2:0] frame_chan;
  logic [13:0] frame_data;
  logic frame_cfg;
  logic output_clear_n;
  logic latch_load_n;
  logic hw_reset_n;
  logic reset_level_select;
  logic data_format_select;
  logic single_supply;
  logic sdo_oe;
  modport device (
    input cs_n, frame_chan, frame_data, frame_cfg, output_clear_n, latch_load_n,
    input hw_reset_n, reset_level_select, data_format_select, single_supply,
    output sdo_oe
  );
  modport host (
    output cs_n, frame_chan, frame_data, frame_cfg, output_clear_n, latch_load_n,
    output hw_reset_n, reset_level_select, data_format_select, single_supply,
    input sdo_oe
  );
endinterface
`default_nettype wire

/* File: duc_device.sv */
// Overview of operation
// - clear low grounds outputs, buffers high impedance
// - load pin ignored during clear; release waits load
// - load tied low: clear release restores latches
// - clear leaves all registers and latches unchanged
// - power-on loads defaults and strap-selected codes
// - input data register resets to zero
// - dual supply reset codes and offset codes
// - single supply disables offset, same codes
// - hardware reset holds reset values and defaults
// - hardware reset blocks frames, sdo high impedance
// - after hardware reset outputs keep reset values
// - host keeps chip select high during reset
// - load level at power-on fixes update mode
// - reload only written channels unless soft load
// - asynchronous mode ignores load pin and bit
// - async, engine off: update on select rise
// - async, engine on: latch follows engine write
// - sync, engine off: load updates eligible latches
// - sync, engine on: load waits for engine
// - sync: no load, latches stay unchanged
// - host raises load before frame, loads after
// - host waits minimum gap before load event
`timescale 1ns/1ps
`default_nettype none
module duc_device (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link to host
  duc_if.device link,
  // converter core side
  output logic [duc_pkg::NUM_CH-1:0][duc_pkg::CODE_W-1:0] analog_code,
  output logic analog_gnd,
  output logic [duc_pkg::CODE_W-1:0] offset_code,
  output logic offset_on,
  output logic [duc_pkg::CODE_W-1:0] gain_code,
  output logic [duc_pkg::CODE_W-1:0] zero_code,
  output logic [duc_pkg::CODE_W-1:0] input_code,
  output logic async_mode,
  output logic mode_valid
);
  import duc_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic duc_code_t rst_code(input logic rsel, input logic fmt);
    rst_code = (rsel ^ fmt) ? CODE_MID : CODE_ZERO;
  endfunction

  function automatic duc_code_t off_code(input logic fmt);
    off_code = fmt ? OFFSET_TC : OFFSET_SB;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s1;
  logic [NUM_PINS-1:0] pin_s2;
  logic [NUM_PINS-1:0] pin_s3;
  logic [NUM_PINS-1:0] pin_flt;
  logic [NUM_PINS-1:0] pin_prev;

  assign pin_raw = {link.single_supply, link.data_format_select, link.reset_level_select,
                    link.cs_n, link.hw_reset_n, link.latch_load_n, link.output_clear_n};

  // a level is accepted only once two stages agree, so a glitch never counts
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_s1 <= PIN_RESET;
      pin_s2 <= PIN_RESET;
      pin_s3 <= PIN_RESET;
      pin_flt <= PIN_RESET;
      pin_prev <= PIN_RESET;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_flt <= (pin_s2 & pin_s3) | (pin_flt & (pin_s2 ^ pin_s3));
      pin_prev <= pin_flt;
    end
  end

  logic clear_low;
  logic load_fall;
  logic cs_rise;
  logic in_hwrst;
  logic init;

  assign clear_low = ~pin_flt[PIN_CLR];
  assign load_fall = pin_prev[PIN_LOAD] & ~pin_flt[PIN_LOAD];
  assign cs_rise = ~pin_prev[PIN_CS] & pin_flt[PIN_CS];
  assign in_hwrst = ~pin_flt[PIN_RST];
  assign init = ~mode_valid | in_hwrst;

  // ----------------------------------------
  // power-on mode capture
  // ----------------------------------------
  logic [2:0] por_cnt;

  // straps are taken only after the synchronisers have settled
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      por_cnt <= 3'h0;
      mode_valid <= 1'b0;
      async_mode <= 1'b0;
    end else if (!mode_valid) begin
      if (por_cnt == POR_SETTLE) begin
        mode_valid <= 1'b1;
        async_mode <= ~pin_flt[PIN_LOAD];
      end else begin
        por_cnt <= por_cnt + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // frame intake and configuration bits
  // ----------------------------------------
  logic take;
  logic soft_load_bit;
  logic correction_engine_on;
  logic ld_pend;
  logic apply;
  logic eng_busy;
  logic [3:0] eng_cnt;
  logic [2:0] eng_chan;
  duc_code_t eng_data;
  logic eng_done;

  assign take = cs_rise & ~init;
  assign eng_done = eng_busy & (eng_cnt == 4'h0);
  // a load never overtakes the engine
  assign apply = ld_pend & ~eng_busy;

  always_ff @(posedge clk_sys) begin
    if (!reset_n || init) begin
      soft_load_bit <= 1'b0;
      correction_engine_on <= 1'b0;
    end else if (take && link.frame_cfg) begin
      soft_load_bit <= link.frame_data[CFG_LOAD_BIT] & ~async_mode;
      correction_engine_on <= link.frame_data[CFG_CORR_BIT];
    end else if (apply) begin
      soft_load_bit <= 1'b0;
    end
  end

  // ----------------------------------------
  // load request
  // ----------------------------------------
  logic ld_trig;

  assign ld_trig = ~async_mode & ((load_fall & ~clear_low) |
                   (take & link.frame_cfg & link.frame_data[CFG_LOAD_BIT]));

  always_ff @(posedge clk_sys) begin
    if (!reset_n || init) begin
      ld_pend <= 1'b0;
    end else if (ld_trig) begin
      ld_pend <= 1'b1;
    end else if (apply) begin
      ld_pend <= 1'b0;
    end
  end

  // ----------------------------------------
  // correction engine timing
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n || init) begin
      eng_busy <= 1'b0;
      eng_cnt <= 4'h0;
      eng_chan <= 3'h0;
      eng_data <= CODE_ZERO;
    end else if (take && !link.frame_cfg && correction_engine_on) begin
      eng_busy <= 1'b1;
      eng_cnt <= CORR_CYCLES;
      eng_chan <= link.frame_chan;
      eng_data <= link.frame_data;
    end else if (eng_done) begin
      eng_busy <= 1'b0;
    end else if (eng_busy) begin
      eng_cnt <= eng_cnt - 4'h1;
    end
  end

  // ----------------------------------------
  // data registers, latches, dirty flags
  // ----------------------------------------
  duc_bank_t data_reg;
  duc_bank_t latch;
  logic [NUM_CH-1:0] dirty;
  logic wr_now;
  logic [2:0] wr_chan;
  duc_code_t wr_data;

  assign wr_now = (take & ~link.frame_cfg & ~correction_engine_on) | eng_done;
  assign wr_chan = eng_done ? eng_chan : link.frame_chan;
  assign wr_data = eng_done ? eng_data : link.frame_data;

  // clear is not consulted here, so it never alters stored codes
  always_ff @(posedge clk_sys) begin
    if (!reset_n || init) begin
      for (int i = 0; i < NUM_CH; i++) begin
        data_reg[i] <= rst_code(pin_flt[PIN_RSEL], pin_flt[PIN_FMT]);
        latch[i] <= rst_code(pin_flt[PIN_RSEL], pin_flt[PIN_FMT]);
      end
      dirty <= '0;
    end else begin
      if (apply) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (dirty[i] || soft_load_bit) begin
            latch[i] <= data_reg[i];
          end
        end
        dirty <= '0;
      end
      // a write in the same cycle as a load keeps its dirty mark
      if (wr_now) begin
        data_reg[wr_chan] <= wr_data;
        dirty[wr_chan] <= 1'b1;
        if (async_mode) begin
          latch[wr_chan] <= wr_data;
        end
      end
    end
  end
  // without a load event latches only change in asynchronous mode
  assign analog_code = latch;

  // ----------------------------------------
  // input data, gain, zero, offset
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n || init) begin
      input_code <= CODE_ZERO;
      gain_code <= GAIN_DEFAULT;
      zero_code <= ZERO_DEFAULT;
      offset_code <= off_code(pin_flt[PIN_FMT]);
      offset_on <= ~pin_flt[PIN_SGL];
    end else if (take && !link.frame_cfg) begin
      input_code <= link.frame_data;
    end
  end

  // ----------------------------------------
  // output clear
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      analog_gnd <= 1'b0;
    end else if (clear_low) begin
      analog_gnd <= 1'b1;
    end else if (!pin_flt[PIN_LOAD]) begin
      analog_gnd <= 1'b0;
    end
  end

  // ----------------------------------------
  // serial output enable
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      link.sdo_oe <= 1'b0;
    end else begin
      link.sdo_oe <= ~init & ~pin_flt[PIN_CS];
    end
  end
endmodule // duc_device
`default_nettype wire

/* File: duc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module duc_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to device
  duc_if.host link
);
  import duc_pkg::*;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_status;
  logic mapped;

  assign pready = penable;
  assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_CMD) | (paddr == ADDR_STATUS);
  assign wr_ctrl = psel & penable & pwrite & (paddr == ADDR_CTRL);
  assign wr_cmd = psel & penable & pwrite & (paddr == ADDR_CMD);
  assign wr_status = psel & penable & pwrite & (paddr == ADDR_STATUS);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [5:0] ctrl;
  logic pulse_pend;
  logic refused;
  duc_host_state_t state;
  logic [7:0] cnt;
  logic busy;
  logic start_frame;

  assign busy = (state != H_IDLE);
  // a frame during hardware reset would be lost, so it is refused
  assign start_frame = wr_cmd & ~busy & ctrl[CTRL_RST];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[5:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      refused <= 1'b0;
    end else if (wr_cmd && !start_frame) begin
      refused <= 1'b1;
    end else if (wr_status && pwdata[ST_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pulse_pend <= 1'b0;
    end else if (wr_ctrl && pwdata[CTRL_PULSE]) begin
      pulse_pend <= 1'b1;
    end else if (state == H_IDLE && !start_frame) begin
      pulse_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= ~mapped;
      case (paddr)
        ADDR_CTRL: prdata <= {26'h0, ctrl};
        ADDR_STATUS: prdata <= {28'h0, link.sdo_oe, refused, pulse_pend, busy};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // frame and load sequencer
  // ----------------------------------------
  logic pulse_low;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= H_IDLE;
      cnt <= 8'h00;
      link.cs_n <= 1'b1;
      pulse_low <= 1'b0;
      link.frame_chan <= 3'h0;
      link.frame_data <= 14'h0000;
      link.frame_cfg <= 1'b0;
    end else begin
      case (state)
        H_IDLE: begin
          if (start_frame) begin
            link.frame_data <= pwdata[13:0];
            link.frame_chan <= pwdata[CMD_CHAN_LSB +: 3];
            link.frame_cfg <= pwdata[CMD_CFG];
            link.cs_n <= 1'b0;
            cnt <= FRAME_LOW_CYCLES - 8'h01;
            state <= H_FRAME;
          end else if (pulse_pend) begin
            pulse_low <= 1'b1;
            cnt <= LOAD_LOW_CYCLES - 8'h01;
            state <= H_PULSE;
          end
        end
        H_FRAME: begin
          if (cnt == 8'h00) begin
            link.cs_n <= 1'b1;
            cnt <= GAP_CYCLES;
            state <= H_GAP;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        H_GAP: begin
          // frame data stays put; the device samples it on select rise
          if (cnt == 8'h00) begin
            state <= H_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        H_PULSE: begin
          if (cnt == 8'h00) begin
            pulse_low <= 1'b0;
            state <= H_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= H_IDLE;
          link.cs_n <= 1'b1;
          pulse_low <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // load stays at its strap level except during a pulse after the gap
  assign link.latch_load_n = ctrl[CTRL_LOAD] & ~pulse_low;
  assign link.output_clear_n = ctrl[CTRL_CLR];
  assign link.hw_reset_n = ctrl[CTRL_RST];
  assign link.reset_level_select = ctrl[CTRL_RSEL];
  assign link.data_format_select = ctrl[CTRL_FMT];
  assign link.single_supply = ctrl[CTRL_SGL];
endmodule // duc_host
`default_nettype wire

/* File: duc_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module duc_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  input wire logic cs_n,
  input wire logic latch_load_n,
  input wire logic output_clear_n,
  input wire logic hw_reset_n,
  input wire logic sdo_oe,
  // device side
  input wire logic [duc_pkg::NUM_CH-1:0][duc_pkg::CODE_W-1:0] analog_code,
  input wire logic analog_gnd,
  input wire logic [duc_pkg::CODE_W-1:0] input_code,
  input wire logic async_mode,
  input wire logic mode_valid
);
  import duc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [7:0] since_cs;
  logic [7:0] quiet;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) since_cs <= 8'hff;
    else if (!cs_n) since_cs <= 8'h00;
    else if (since_cs != 8'hff) since_cs <= since_cs + 8'h01;
  end
  // frames and resets restart it: their effects land late
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !cs_n || !latch_load_n || !hw_reset_n) quiet <= 8'h00;
    else if (quiet != 8'hff) quiet <= quiet + 8'h01;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_clear_grounds: assert property (!output_clear_n [*6] |-> analog_gnd)
    else $error("outputs not grounded under clear");
  a_clear_waits_load: assert property (latch_load_n [*5] ##0 analog_gnd |=> analog_gnd)
    else $error("clear released without load");
  a_clear_keeps_latch: assert property ($fell(output_clear_n) && cs_n && hw_reset_n
    |=> $stable(analog_code) [*6])
    else $error("clear changed latches");
  a_input_reset_zero: assert property (!hw_reset_n [*6] |-> input_code == CODE_ZERO)
    else $error("input register not zero in reset");
  a_sdo_reset_quiet: assert property (!hw_reset_n [*6] |-> !sdo_oe)
    else $error("sdo driven in reset");
  a_cs_high_reset: assert property (!hw_reset_n |-> cs_n)
    else $error("frame during hardware reset");
  a_mode_from_load: assert property ($rose(mode_valid)
    |-> async_mode == !$past(latch_load_n, 5))
    else $error("update mode wrong");
  a_sync_hold: assert property (!async_mode && mode_valid && quiet > 8'h14
    |-> $stable(analog_code))
    else $error("latch moved without load");
  a_load_before_frame: assert property ($fell(cs_n) && mode_valid && !async_mode
    |-> latch_load_n)
    else $error("load low at frame start");
  a_load_gap: assert property ($fell(latch_load_n) |-> since_cs >= GAP_CYCLES)
    else $error("load too soon after frame");
  c_clear: cover property ($rose(analog_gnd));
  c_sync_load: cover property ($fell(latch_load_n) && !async_mode && mode_valid);
  c_async: cover property ($rose(mode_valid) && async_mode);
endmodule // duc_properties
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import duc_pkg::*;
  logic clk_sys = 1'b0;
  logic host_rst_n = 1'b0;
  logic dev_rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  duc_bank_t analog_code;
  duc_bank_t exp_lat;
  logic analog_gnd;
  logic offset_on;
  logic async_mode;
  logic mode_valid;
  duc_code_t offset_code;
  duc_code_t gain_code;
  duc_code_t zero_code;
  duc_code_t input_code;
  duc_code_t code;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int compares = 0;
  duc_if link ();
  duc_host i_duc_host (.clk_sys(clk_sys), .reset_n(host_rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  duc_device i_duc_device (.clk_sys(clk_sys), .reset_n(dev_rst_n), .link(link),
    .analog_code(analog_code), .analog_gnd(analog_gnd), .offset_code(offset_code),
    .offset_on(offset_on), .gain_code(gain_code), .zero_code(zero_code),
    .input_code(input_code), .async_mode(async_mode), .mode_valid(mode_valid));
  duc_properties i_duc_properties (.clk_sys(clk_sys), .reset_n(dev_rst_n), .cs_n(link.cs_n),
    .latch_load_n(link.latch_load_n), .output_clear_n(link.output_clear_n),
    .hw_reset_n(link.hw_reset_n), .sdo_oe(link.sdo_oe), .analog_code(analog_code),
    .analog_gnd(analog_gnd), .input_code(input_code), .async_mode(async_mode),
    .mode_valid(mode_valid));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task fail_to;
    errors++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask
  task chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_bank;
    for (int i = 0; i < NUM_CH; i++) chk(analog_code[i], exp_lat[i]);
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_to();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // settle covers pin filters plus the engine delay
  task wait_idle;
    for (int n = 0; n < 100; n++) begin
      apb(ADDR_STATUS, 1'b0, 32'h0);
      if (rd[1:0] === 2'b00) begin
        repeat (16) @(posedge clk_sys);
        return;
      end
    end
    fail_to();
  endtask
  task send(input logic [2:0] ch, input logic [13:0] d, input logic c);
    apb(ADDR_CMD, 1'b1, {11'h0, c, 1'b0, ch, 2'h0, d});
    wait_idle();
  endtask
  task ctrl(input logic [8:0] v);
    apb(ADDR_CTRL, 1'b1, {23'h0, v});
    wait_idle();
  endtask
  task wait_mode;
    for (int n = 0; n < 60; n++) begin
      @(posedge clk_sys);
      if (mode_valid === 1'b1) return;
    end
    fail_to();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_to();
  end
  initial begin
    exp_lat = '0;
    repeat (20) @(posedge clk_sys);
    host_rst_n <= 1'b1;
    dev_rst_n <= 1'b1;
    wait_mode();
    chk(14'(async_mode), 14'h0);
    chk(input_code, CODE_ZERO);
    chk(gain_code, GAIN_DEFAULT);
    chk(zero_code, ZERO_DEFAULT);
    chk(offset_code, OFFSET_SB);
    chk_bank();
    apb(12'h0ff, 1'b0, 32'h0);
    chk(14'(er), 14'h1);
    apb(ADDR_CTRL, 1'b0, 32'h0);
    chk(rd[13:0], 14'(CTRL_RESET));
    send(3'h2, 14'h1234, 1'b0);
    chk(input_code, 14'h1234);
    chk_bank();
    ctrl(9'h107);
    exp_lat[2] = 14'h1234;
    chk_bank();
    send(3'h5, 14'h0abc, 1'b0);
    send(3'h0, 14'h0001, 1'b1);
    exp_lat[5] = 14'h0abc;
    chk_bank();
    send(3'h0, 14'h0002, 1'b1);
    send(3'h1, 14'h0777, 1'b0);
    chk_bank();
    ctrl(9'h107);
    exp_lat[1] = 14'h0777;
    chk_bank();
    send(3'h0, 14'h0000, 1'b1);
    ctrl(9'h006);
    chk(14'(analog_gnd), 14'h1);
    send(3'h3, 14'h0333, 1'b0);
    ctrl(9'h106);
    chk_bank();
    ctrl(9'h007);
    chk(14'(analog_gnd), 14'h1);
    ctrl(9'h107);
    exp_lat[3] = 14'h0333;
    chk(14'(analog_gnd), 14'h0);
    chk_bank();
    // every strap pattern under hardware reset
    for (int i = 0; i < 8; i++) begin
      ctrl({3'h0, 3'(i), 3'h3});
      code = (i[0] ^ i[1]) ? CODE_MID : CODE_ZERO;
      exp_lat = {NUM_CH{code}};
      chk_bank();
      chk(14'(offset_on), 14'(!i[2]));
      if (!i[2]) chk(offset_code, i[1] ? OFFSET_TC : OFFSET_SB);
      chk(input_code, CODE_ZERO);
    end
    apb(ADDR_CMD, 1'b1, 32'h0000_1111);
    apb(ADDR_STATUS, 1'b0, 32'h0);
    chk(14'(rd[ST_REFUSED]), 14'h1);
    apb(ADDR_STATUS, 1'b1, 32'h0000_0004);
    ctrl(9'h03f);
    chk_bank();
    send(3'h4, 14'h0444, 1'b0);
    ctrl(9'h13f);
    exp_lat[4] = 14'h0444;
    chk_bank();
    // power up again with load held low
    dev_rst_n <= 1'b0;
    ctrl(9'h005);
    dev_rst_n <= 1'b1;
    wait_mode();
    chk(14'(async_mode), 14'h1);
    exp_lat = '0;
    chk_bank();
    send(3'h6, 14'h0666, 1'b0);
    exp_lat[6] = 14'h0666;
    chk_bank();
    send(3'h0, 14'h0002, 1'b1);
    send(3'h7, 14'h1777, 1'b0);
    exp_lat[7] = 14'h1777;
    chk_bank();
    ctrl(9'h004);
    chk(14'(analog_gnd), 14'h1);
    ctrl(9'h005);
    chk(14'(analog_gnd), 14'h0);
    chk_bank();
    close_out();
  end
endmodule // testbench
`default_nettype wire
